// ### hw/mcl_lock_fault.sv
// Current-limit and lock-fault supervisor with AHB-Lite register slave
// Assumes motor observations synchronous to clk from the estimator front end
//
// Summary of operation
// (RULE1) Decode 7-bit advance code, 0 to 4800 us
// (RULE2) Advance equals 2.5us mantissa shifted by exponent
// (RULE3) Start current limit only caps voltage, no fault
// (RULE4) Overcurrent fixed, always on, resumes when cleared
// (RULE5) Voltage cap from threshold, resistance, speed, bemf
// (RULE6) Accel limit only closed loop, never faults
// (RULE7) Six lock conditions each with enable bit
// (RULE8) Enabled lock sets motor locked flag
// (RULE9) Cause record sets bits even when disabled
// (RULE10) Cause record cleared on motor restart
// (RULE11) Fault floats phases and starts anti-surge
// (RULE12) Restart automatically after lock-off wait
// (RULE13) Low-side current over threshold causes lock
// (RULE14) Software sets lock threshold above accel limit
// (RULE15) Lock-off wait counted in core clock cycles
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module mcl_lock_fault #(
   parameter int LOCK_OFF_CYCLES = mcl_pkg::LOCK_OFF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Motor observations
   input wire mcl_pkg::mcl_motor_t motorIn,
   input wire logic [15:0] demandVolt,
   // Drive control
   output logic phaseHiZ,
   output logic antiSurge,
   output logic restartReq,
   output logic [15:0] appliedVolt,
   output logic [15:0] advanceHalfUs,
   output logic motorLocked,
   // Interrupt
   output logic irq
);
   import mcl_pkg::*;

   // ---------------------------------------------------------------
   // Bus address phase capture
   // ---------------------------------------------------------------
   logic wrPend_ff, nxt_wrPend;
   logic [7:0] addr_ff, nxt_addr;
   logic [ADV_W-1:0] advCode_ff, nxt_advCode;
   logic [ACC_W-1:0] accThr_ff, nxt_accThr;
   logic [LCK_W-1:0] lckThr_ff, nxt_lckThr;
   logic [7:0] phaseRes_ff, nxt_phaseRes;
   logic [7:0] bemfK_ff, nxt_bemfK;
   logic [NLOCK-1:0] schemeEn_ff, nxt_schemeEn;
   logic [NLOCK-1:0] cause_ff, nxt_cause;
   logic [NIRQ-1:0] irqStat_ff, nxt_irqStat;
   logic [NIRQ-1:0] irqMask_ff, nxt_irqMask;
   logic locked_ff, nxt_locked;
   mcl_state_t state_ff, nxt_state;
   logic [31:0] cnt_ff, nxt_cnt;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [15:0] volt_ff, nxt_volt;
   logic [15:0] adv_ff, nxt_adv;
   logic accActive_ff, nxt_accActive;
   logic lockHit, ocNow, restartPulse, wrHit;
   logic [23:0] uLimit;

   // Advance code decode: mantissa times 2.5 us, shifted by exponent
   function automatic logic [15:0] advDecode(input logic [ADV_W-1:0] code);
      logic [15:0] base;
      base = 16'(code[3:0]) * 16'(ADV_UNIT_HALF_US);
      return base << code[6:4]; // see (RULE1) (RULE2)
   endfunction

   always_comb begin
      nxt_wrPend = 1'b0;
      nxt_addr = addr_ff;
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
         nxt_addr = haddr[7:0];
         nxt_wrPend = hwrite;
      end
   end
   assign wrHit = wrPend_ff;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_comb begin
      nxt_advCode = advCode_ff;
      nxt_accThr = accThr_ff;
      nxt_lckThr = lckThr_ff;
      nxt_phaseRes = phaseRes_ff;
      nxt_bemfK = bemfK_ff;
      nxt_schemeEn = schemeEn_ff;
      nxt_irqMask = irqMask_ff;
      if (wrHit) begin
         unique case (addr_ff)
            OFF_ADVANCE: nxt_advCode = hwdata[ADV_W-1:0];
            OFF_LIMITS: begin
               nxt_accThr = hwdata[ACC_W-1:0];
               nxt_lckThr = hwdata[LIM_HW_POS +: LCK_W];
            end
            OFF_MOTOR: begin
               nxt_phaseRes = hwdata[7:0];
               nxt_bemfK = hwdata[MOT_BEMF_POS +: 8];
            end
            OFF_SCHEME_EN: nxt_schemeEn = hwdata[NLOCK-1:0]; // see (RULE7)
            OFF_IRQMASK: nxt_irqMask = hwdata[NIRQ-1:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Acceleration voltage cap
   // ---------------------------------------------------------------
   // Current is never measured here; the cap comes from the motor model only
   assign uLimit = 24'(accThr_ff) * 24'(phaseRes_ff) + 24'(motorIn.speed) * 24'(bemfK_ff); // see (RULE5)
   always_comb begin
      nxt_volt = demandVolt;
      nxt_accActive = 1'b0;
      if (motorIn.closedLoop && 24'(demandVolt) > uLimit) begin // see (RULE6)
         nxt_volt = uLimit[15:0];
         nxt_accActive = 1'b1; // see (RULE3)
      end
      nxt_adv = advDecode(advCode_ff);
   end

   // ---------------------------------------------------------------
   // Lock detection and fault sequencing
   // ---------------------------------------------------------------
   logic [NLOCK-1:0] condAll;
   always_comb begin
      condAll = motorIn.cond;
      // Condition 0 is the observed condition 0 or the low-side current over its threshold
      condAll[0] = motorIn.cond[0] || (motorIn.lowSideCurrent > {lckThr_ff, 4'h0}); // see (RULE13)
   end
   assign lockHit = |(condAll & schemeEn_ff); // see (RULE7)
   assign ocNow = motorIn.overCurrent; // see (RULE4)
   assign restartPulse = (state_ff == ST_RESTART);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_locked = locked_ff;
      nxt_cause = cause_ff | condAll; // see (RULE9)
      unique case (state_ff)
         ST_RUN: begin
            if (lockHit) begin
               nxt_state = ST_FLOAT; // see (RULE11)
               nxt_locked = 1'b1; // see (RULE8)
               nxt_cnt = 32'(SURGE_CYC);
            end
         end
         ST_FLOAT: begin
            nxt_cnt = cnt_ff - 32'h1;
            if (cnt_ff <= 32'h1) begin
               nxt_state = ST_WAIT;
               nxt_cnt = 32'(LOCK_OFF_CYCLES);
            end
         end
         ST_WAIT: begin
            nxt_cnt = cnt_ff - 32'h1; // see (RULE15)
            if (cnt_ff <= 32'h1) begin
               nxt_state = ST_RESTART; // see (RULE12)
            end
         end
         ST_RESTART: begin
            nxt_state = ST_RUN;
            nxt_locked = 1'b0;
            nxt_cause = condAll; // see (RULE10)
            nxt_cnt = 32'h0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Interrupt status, write-one-to-clear, set wins
   // ---------------------------------------------------------------
   logic [NIRQ-1:0] irqEv;
   always_comb begin
      irqEv = '0;
      irqEv[IRQ_LOCK] = (state_ff == ST_RUN) && lockHit;
      irqEv[IRQ_OC] = ocNow;
      irqEv[IRQ_RESTART] = restartPulse;
      nxt_irqStat = irqStat_ff;
      if (wrHit && addr_ff == OFF_IRQSTAT) begin
         nxt_irqStat = irqStat_ff & ~hwdata[NIRQ-1:0];
      end
      nxt_irqStat = nxt_irqStat | irqEv;
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_comb begin
      nxt_rdata = 32'h0;
      if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
         unique case (haddr[7:0])
            OFF_ADVANCE: nxt_rdata = 32'(advCode_ff);
            OFF_LIMITS: nxt_rdata = 32'(accThr_ff) | (32'(lckThr_ff) << LIM_HW_POS);
            OFF_MOTOR: nxt_rdata = 32'(phaseRes_ff) | (32'(bemfK_ff) << MOT_BEMF_POS);
            OFF_SCHEME_EN: nxt_rdata = 32'(schemeEn_ff);
            OFF_STATUS: nxt_rdata = 32'({accActive_ff, phaseHiZ, ocNow, locked_ff});
            OFF_CAUSE: nxt_rdata = 32'(cause_ff);
            OFF_IRQSTAT: nxt_rdata = 32'(irqStat_ff);
            OFF_IRQMASK: nxt_rdata = 32'(irqMask_ff);
            OFF_ULIMIT: nxt_rdata = 32'(uLimit);
            OFF_ADVOUT: nxt_rdata = 32'(adv_ff);
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPend_ff <= 1'b0;
         addr_ff <= 8'h00;
         advCode_ff <= RST_ADVANCE;
         accThr_ff <= RST_ACC;
         lckThr_ff <= RST_LCK;
         phaseRes_ff <= 8'h00;
         bemfK_ff <= 8'h00;
         schemeEn_ff <= RST_SCHEME_EN;
         cause_ff <= '0;
         irqStat_ff <= '0;
         irqMask_ff <= '0;
         locked_ff <= 1'b0;
         state_ff <= ST_RUN;
         cnt_ff <= 32'h0;
         rdata_ff <= 32'h0;
         volt_ff <= 16'h0000;
         adv_ff <= 16'h0000;
         accActive_ff <= 1'b0;
      end else begin
         wrPend_ff <= nxt_wrPend;
         addr_ff <= nxt_addr;
         advCode_ff <= nxt_advCode;
         accThr_ff <= nxt_accThr;
         lckThr_ff <= nxt_lckThr;
         phaseRes_ff <= nxt_phaseRes;
         bemfK_ff <= nxt_bemfK;
         schemeEn_ff <= nxt_schemeEn;
         cause_ff <= nxt_cause;
         irqStat_ff <= nxt_irqStat;
         irqMask_ff <= nxt_irqMask;
         locked_ff <= nxt_locked;
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         rdata_ff <= nxt_rdata;
         volt_ff <= nxt_volt;
         adv_ff <= nxt_adv;
         accActive_ff <= nxt_accActive;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Overcurrent floats the bridge directly, with no wait: protection must not lag
   assign phaseHiZ = (state_ff != ST_RUN) || ocNow; // see (RULE4) (RULE11)
   assign antiSurge = (state_ff == ST_FLOAT); // see (RULE11)
   assign restartReq = restartPulse; // see (RULE12)
   assign appliedVolt = volt_ff;
   assign advanceHalfUs = adv_ff;
   assign motorLocked = locked_ff;
   assign irq = |(irqStat_ff & irqMask_ff);
   assign hrdata = rdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_lockEntry;
      state_ff == ST_RUN && lockHit;
   endsequence
   sequence s_floatSeen;
      ##1 (antiSurge && phaseHiZ && motorLocked);
   endsequence

   AST_ADV_DECODE: assert property (@(posedge clk) disable iff (rst) // see (RULE2)
      ##1 advanceHalfUs == (16'($past(advCode_ff[3:0])) * 16'h5) << $past(advCode_ff[6:4]))
      else $error("advance decode wrong");
   AST_ADV_MAX: assert property (@(posedge clk) disable iff (rst) // see (RULE1)
      advCode_ff == 7'h7F |=> advanceHalfUs == 16'h2580)
      else $error("largest advance not 4800 us");
   AST_ACC_NOFAULT: assert property (@(posedge clk) disable iff (rst) // see (RULE3)
      (state_ff == ST_RUN && !lockHit && accActive_ff) |=> state_ff == ST_RUN)
      else $error("accel limit caused fault");
   AST_ACC_CAP: assert property (@(posedge clk) disable iff (rst) // see (RULE5)
      (motorIn.closedLoop && 24'(demandVolt) > uLimit) |=> appliedVolt == $past(uLimit[15:0]))
      else $error("voltage cap not applied");
   AST_ACC_OPEN: assert property (@(posedge clk) disable iff (rst) // see (RULE6)
      !motorIn.closedLoop |=> appliedVolt == $past(demandVolt))
      else $error("accel limit active in open loop");
   AST_OC_FLOAT: assert property (@(posedge clk) disable iff (rst) // see (RULE4)
      motorIn.overCurrent |-> phaseHiZ)
      else $error("overcurrent did not float bridge");
   AST_LOCK_ENTRY: assert property (@(posedge clk) disable iff (rst) // see (RULE8) (RULE11)
      s_lockEntry |-> s_floatSeen)
      else $error("lock entry sequence wrong");
   AST_LOCK_DISABLED: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (state_ff == ST_RUN && (condAll & schemeEn_ff) == '0) |=> state_ff == ST_RUN)
      else $error("disabled condition locked motor");
   AST_CAUSE_SET: assert property (@(posedge clk) disable iff (rst) // see (RULE9)
      (state_ff != ST_RESTART) |=> (cause_ff & $past(condAll)) == $past(condAll))
      else $error("cause bit not recorded");
   AST_CAUSE_CLR: assert property (@(posedge clk) disable iff (rst) // see (RULE10)
      (restartReq && condAll == '0) |=> cause_ff == '0)
      else $error("cause record not cleared at restart");
   AST_WAIT_RESTART: assert property (@(posedge clk) disable iff (rst) // see (RULE12) (RULE15)
      (state_ff == ST_WAIT && cnt_ff == 32'h1) |=> restartReq ##1 !phaseHiZ || motorIn.overCurrent || lockHit)
      else $error("restart after lock-off wrong");
   AST_LOWSIDE: assert property (@(posedge clk) disable iff (rst) // see (RULE13)
      (state_ff == ST_RUN && schemeEn_ff[0] && motorIn.lowSideCurrent > {lckThr_ff, 4'h0}) |=> motorLocked)
      else $error("low-side overcurrent not locked");
endmodule // mcl_lock_fault

// ### include/mcl_pkg.sv
// Constants, register map and carrier types for the motor current-limit / lock-fault block
// Assumes a single 200 MHz core clock and a 32-bit AHB-Lite register bus
package mcl_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_ADVANCE = 8'h00;
   localparam logic [7:0] OFF_LIMITS = 8'h04;
   localparam logic [7:0] OFF_MOTOR = 8'h08;
   localparam logic [7:0] OFF_SCHEME_EN = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_CAUSE = 8'h14;
   localparam logic [7:0] OFF_IRQSTAT = 8'h18;
   localparam logic [7:0] OFF_IRQMASK = 8'h1C;
   localparam logic [7:0] OFF_ULIMIT = 8'h20;
   localparam logic [7:0] OFF_ADVOUT = 8'h24;
   // ---------------------------------------------------------------
   // Field positions and widths
   // ---------------------------------------------------------------
   localparam int ADV_W = 7;
   localparam int ACC_W = 4;
   localparam int LCK_W = 3;
   localparam int NLOCK = 6;
   localparam int LIM_HW_POS = 8;
   localparam int MOT_BEMF_POS = 8;
   localparam int MOT_CL_POS = 16;
   localparam int ST_LOCK = 0;
   localparam int ST_OC = 1;
   localparam int ST_HIZ = 2;
   localparam int ST_ACC = 3;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_OC = 1;
   localparam int IRQ_RESTART = 2;
   localparam int NIRQ = 3;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [ADV_W-1:0] RST_ADVANCE = 7'h00;
   localparam logic [NLOCK-1:0] RST_SCHEME_EN = 6'h3F;
   localparam logic [ACC_W-1:0] RST_ACC = 4'h0;
   localparam logic [LCK_W-1:0] RST_LCK = 3'h7;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int LOCK_OFF_MS = 5;
   localparam int LOCK_OFF_CYC = LOCK_OFF_MS * 1000 * CLK_MHZ;
   localparam int SURGE_US = 1;
   localparam int SURGE_CYC = SURGE_US * CLK_MHZ;
   // Advance time in units of 0.5 us: 2.5 us = 5 half-microseconds
   localparam logic [3:0] ADV_UNIT_HALF_US = 4'h5;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_FLOAT = 2'b01,
      ST_WAIT = 2'b10,
      ST_RESTART = 2'b11
   } mcl_state_t;
   typedef struct packed {
      logic [NLOCK-1:0] cond;
      logic overCurrent;
      logic closedLoop;
      logic [15:0] speed;
      logic [LCK_W+4:0] lowSideCurrent;
   } mcl_motor_t;
endpackage

// ### verif/mcl_motor_model.sv
// Motor windings model: turns bench commands into estimator observations
// Assumes commands change just after a rising clk edge
`timescale 1ns/1ps
module mcl_motor_model (
   // Clock and bridge state
   input wire logic clk,
   input wire logic phaseHiZ,
   // Bench commands
   input wire logic [5:0] condCmd,
   input wire logic ocCmd,
   input wire logic loopCmd,
   input wire logic [15:0] speedCmd,
   input wire logic [7:0] curCmd,
   // Observations
   output mcl_pkg::mcl_motor_t motorIn
);
   import mcl_pkg::*;
   initial motorIn = '0;
   // A floated bridge carries no winding current, so the low-side sense reads zero
   always @(posedge clk) begin
      motorIn.cond <= condCmd;
      motorIn.overCurrent <= ocCmd;
      motorIn.closedLoop <= loopCmd;
      motorIn.speed <= speedCmd;
      motorIn.lowSideCurrent <= phaseHiZ ? 8'h00 : curCmd;
   end
endmodule // mcl_motor_model

// ### verif/tb.sv
// Self-checking bench for the lock-fault supervisor
// Assumes the motor model on motorIn and a shortened lock-off wait
`timescale 1ns/1ps
module tb;
   import mcl_pkg::*;
   // Short lock-off keeps the run small; timing checks derive from it
   localparam int LOFF = 20;
   logic clk, rst, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic phaseHiZ, antiSurge, restartReq, motorLocked, irq, ocCmd, loopCmd;
   logic [15:0] demandVolt, appliedVolt, advanceHalfUs, speedCmd;
   logic [5:0] condCmd;
   logic [7:0] curCmd;
   mcl_motor_t motorIn;
   int fails, n_tests, n;

   mcl_lock_fault #(.LOCK_OFF_CYCLES(LOFF)) i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .motorIn(motorIn), .demandVolt(demandVolt), .phaseHiZ(phaseHiZ),
      .antiSurge(antiSurge), .restartReq(restartReq), .appliedVolt(appliedVolt),
      .advanceHalfUs(advanceHalfUs), .motorLocked(motorLocked), .irq(irq));
   mcl_motor_model i_motor (.clk(clk), .phaseHiZ(phaseHiZ), .condCmd(condCmd), .ocCmd(ocCmd),
      .loopCmd(loopCmd), .speedCmd(speedCmd), .curCmd(curCmd), .motorIn(motorIn));

   // -------------------------------------------------------------
   // Bus and compare helpers
   // -------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp, input string m);
      chk({31'h0, got}, {31'h0, exp}, m);
   endtask
   task automatic waitSig(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic testRegs;
      bus(1'b0, OFF_SCHEME_EN, 32'h0);
      chk(rdv, {26'h0, RST_SCHEME_EN}, "enable reset");
      bus(1'b0, OFF_LIMITS, 32'h0);
      chk(rdv, {21'h0, RST_LCK, 4'h0, RST_ACC}, "limit reset");
      bus(1'b0, 8'h40, 32'h0);
      chk(rdv, 32'h0, "unmapped read");
      chkb(hresp, 1'b0, "response");
      $display("testRegs done");
   endtask
   task automatic testAdvance;
      logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h28, 8'h5F, 8'h7F};
      logic [15:0] e;
      foreach (codes[i]) begin
         e = (16'h0005 * codes[i][3:0]) << codes[i][6:4];
         bus(1'b1, OFF_ADVANCE, {24'h0, codes[i]});
         repeat (2) @(posedge clk);
         chk({16'h0, advanceHalfUs}, {16'h0, e}, "advance out");
         bus(1'b0, OFF_ADVOUT, 32'h0);
         chk(rdv, {16'h0, e}, "advance read");
      end
      $display("testAdvance done");
   endtask
   task automatic testAccel;
      bus(1'b1, OFF_LIMITS, 32'h0000_0703);
      bus(1'b1, OFF_MOTOR, 32'h0000_020A);
      speedCmd <= 16'h0064;
      demandVolt <= 16'h03E8;
      loopCmd <= 1'b1;
      repeat (4) @(posedge clk);
      chk({16'h0, appliedVolt}, 32'h0000_00E6, "capped volt");
      chkb(motorLocked | phaseHiZ | irq, 1'b0, "no fault");
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(rdv, 32'h0000_0008, "limit active status");
      bus(1'b0, OFF_ULIMIT, 32'h0);
      chk(rdv, 32'h0000_00E6, "limit value");
      demandVolt <= 16'h0064;
      repeat (4) @(posedge clk);
      chk({16'h0, appliedVolt}, 32'h0000_0064, "below cap");
      loopCmd <= 1'b0;
      demandVolt <= 16'h03E8;
      repeat (4) @(posedge clk);
      chk({16'h0, appliedVolt}, 32'h0000_03E8, "open loop");
      $display("testAccel done");
   endtask
   task automatic testOvercurrent;
      bus(1'b1, OFF_IRQMASK, 32'h2);
      ocCmd <= 1'b1;
      repeat (3) @(posedge clk);
      chkb(phaseHiZ, 1'b1, "oc float");
      chkb(motorLocked, 1'b0, "oc not lock");
      chkb(irq, 1'b1, "oc irq");
      ocCmd <= 1'b0;
      repeat (3) @(posedge clk);
      chkb(phaseHiZ, 1'b0, "oc resume");
      bus(1'b1, OFF_IRQSTAT, 32'h2);
      @(posedge clk);
      chkb(irq, 1'b0, "irq clear");
      bus(1'b1, OFF_IRQMASK, 32'h0);
      ocCmd <= 1'b1;
      repeat (3) @(posedge clk);
      ocCmd <= 1'b0;
      chkb(irq, 1'b0, "irq masked");
      bus(1'b0, OFF_IRQSTAT, 32'h0);
      chk(rdv, 32'h2, "irq sticky");
      bus(1'b1, OFF_IRQSTAT, 32'h2);
      $display("testOvercurrent done");
   endtask
   task automatic testLock;
      int t;
      bus(1'b1, OFF_SCHEME_EN, 32'h3B);
      condCmd <= 6'h04;
      repeat (4) @(posedge clk);
      chkb(motorLocked, 1'b0, "disabled");
      bus(1'b0, OFF_CAUSE, 32'h0);
      chk(rdv, 32'h04, "cause disabled");
      bus(1'b1, OFF_IRQMASK, 32'h1);
      condCmd <= 6'h02;
      waitSig(motorLocked, 10);
      condCmd <= 6'h00;
      chkb(motorLocked, 1'b1, "locked");
      chkb(antiSurge & phaseHiZ & irq, 1'b1, "float surge");
      bus(1'b0, OFF_CAUSE, 32'h0);
      chk(rdv, 32'h06, "cause kept");
      waitSig(restartReq, 600);
      t = n + 3;
      chkb(t >= SURGE_CYC + LOFF - 1 && t <= SURGE_CYC + LOFF + 2, 1'b1, "lock-off time");
      chkb(phaseHiZ & ~antiSurge, 1'b1, "wait floated");
      repeat (3) @(posedge clk);
      chkb(motorLocked | phaseHiZ, 1'b0, "restarted");
      bus(1'b0, OFF_CAUSE, 32'h0);
      chk(rdv, 32'h0, "cause cleared");
      bus(1'b0, OFF_IRQSTAT, 32'h0);
      chk(rdv, 32'h5, "irq events");
      bus(1'b1, OFF_IRQSTAT, 32'h7);
      @(posedge clk);
      chkb(irq, 1'b0, "irq done");
      $display("testLock done");
   endtask
   task automatic testLowSide;
      bus(1'b1, OFF_LIMITS, 32'h0000_0201);
      curCmd <= 8'h20;
      repeat (4) @(posedge clk);
      chkb(motorLocked, 1'b0, "at threshold");
      curCmd <= 8'h21;
      waitSig(motorLocked, 10);
      curCmd <= 8'h00;
      chkb(motorLocked & phaseHiZ, 1'b1, "over threshold");
      bus(1'b0, OFF_CAUSE, 32'h0);
      chk(rdv, 32'h01, "cause current");
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(rdv, 32'h0000_0005, "locked status");
      waitSig(restartReq, 600);
      chkb(restartReq, 1'b1, "retry");
      $display("testLowSide done");
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run is a few hundred cycles; the limit leaves ample margin
   initial begin
      #100000;
      fails++;
      conclude;
   end
   initial begin
      {rst, hsel, hwrite, ocCmd, loopCmd} = 5'h10;
      {haddr, hwdata, htrans, hsize} = '0;
      {demandVolt, speedCmd, condCmd, curCmd} = '0;
      fails = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      testRegs;
      testAdvance;
      testAccel;
      testOvercurrent;
      testLock;
      testLowSide;
      conclude;
   end
endmodule // tb
